// ### dv/spi_clock_stop_props.sv
`timescale 1ns/1ps
`default_nettype none
module spi_clock_stop_props
	import spi_clock_stop_pkg::*;
#(
	parameter int DIV_W = 8
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Configuration
	input wire logic master_mode_i,
	input wire logic [1:0] clock_stop_phase_sel_i,
	input wire logic tx_sync_polarity_i,
	input wire logic rate_gen_source_sel_i,
	input wire logic [DIV_W-1:0] rate_gen_divider_i,
	// Pins
	input wire logic tx_frame_sync_i,
	input wire logic tx_bit_clock_o,
	input wire logic tx_frame_sync_o,
	input wire logic serial_data_out_o,
	input wire logic serial_data_out_oe_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// Exact cycle figures hold only for one-tick phases taken from the core clock
	wire logic fast = rate_gen_source_sel_i && rate_gen_divider_i == DIV_W'(1);
	wire logic mst = master_mode_i && tx_sync_polarity_i;
	wire logic m10 = mst && fast && clock_stop_phase_sel_i == STOP_SAMPLE_FALL;
	wire logic m11 = mst && fast && clock_stop_phase_sel_i == STOP_SAMPLE_RISE;
	wire logic slv = !master_mode_i && tx_sync_polarity_i;
	sequence s_lead11;
		!tx_bit_clock_o[*2] ##1 tx_bit_clock_o;
	endsequence
	AST_IDLE_LOW: assert property (mst && tx_frame_sync_o |-> !tx_bit_clock_o)
		else $error("clock not low outside frame");
	AST_EN_FIRST: assert property (mst && $rose(tx_bit_clock_o) |-> !$past(tx_frame_sync_o))
		else $error("clock rose before enable");
	AST_LEAD_10: assert property (m10 && $fell(tx_frame_sync_o) |-> !tx_bit_clock_o ##1 tx_bit_clock_o)
		else $error("lead-in wrong in fall mode");
	AST_LEAD_11: assert property (m11 && $fell(tx_frame_sync_o) |-> s_lead11)
		else $error("lead-in wrong in rise mode");
	AST_TAIL_10: assert property (m10 && $rose(tx_frame_sync_o) |-> $past(tx_bit_clock_o, 3)
		&& !$past(tx_bit_clock_o, 2) && !$past(tx_bit_clock_o)) else $error("tail wrong in fall mode");
	AST_TAIL_11: assert property (m11 && $rose(tx_frame_sync_o) |-> $past(tx_bit_clock_o, 2)
		&& !$past(tx_bit_clock_o)) else $error("tail wrong in rise mode");
	AST_DX_OFF_10: assert property (m10 && $fell(serial_data_out_oe_o) |-> !tx_frame_sync_o
		&& !$past(tx_bit_clock_o) && $past(tx_bit_clock_o, 2)) else $error("data release wrong");
	AST_LAUNCH_10: assert property (m10 && serial_data_out_oe_o && $past(serial_data_out_oe_o)
		&& $changed(serial_data_out_o) |-> $rose(tx_bit_clock_o)) else $error("launch not on rise");
	AST_LAUNCH_11: assert property (m11 && serial_data_out_oe_o && $past(serial_data_out_oe_o)
		&& $changed(serial_data_out_o) |-> $fell(tx_bit_clock_o)) else $error("launch not on fall");
	AST_SLV_OFF: assert property (slv && $rose(tx_frame_sync_i) |-> ##[1:4] !serial_data_out_oe_o)
		else $error("slave data not released");
endmodule
bind spi_clock_stop spi_clock_stop_props #(.DIV_W(DIV_W)) i_spi_clock_stop_props (
	.core_clk_i, .rst_i, .master_mode_i, .clock_stop_phase_sel_i, .tx_sync_polarity_i,
	.rate_gen_source_sel_i, .rate_gen_divider_i, .tx_frame_sync_i, .tx_bit_clock_o,
	.tx_frame_sync_o, .serial_data_out_o, .serial_data_out_oe_o);
`default_nettype wire

// ### dv/spi_clock_stop_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module spi_clock_stop_tb_top;
	import spi_clock_stop_pkg::*;
	logic core_clk_i, rst_i, master_mode_i, tx_clock_polarity_i, tx_sync_polarity_i;
	logic rx_sync_polarity_i, tx_clock_direction_i, rx_clock_direction_i, tx_sync_direction_i;
	logic rx_sync_direction_i, rate_gen_source_sel_i, tx_valid_i, rx_ready_i, sck, csn, mosi;
	logic config_error_o, tx_bit_clock_o, tx_bit_clock_oe_o, tx_frame_sync_o, tx_frame_sync_oe_o;
	logic serial_data_out_o, serial_data_out_oe_o, tx_ready_o, rx_valid_o, rx_overrun_o, miso, prev;
	logic [1:0] clock_stop_phase_sel_i, ext_cnt;
	logic [7:0] rate_gen_divider_i, tx_data_i, rx_data_o, pbyte, prx;
	logic [7:0] rxq[$];
	int mismatches, checks, takes, run, hlen, llen;
	wire logic ext_rate_clk_i = ext_cnt[1];
	wire logic serial_data_in_i = master_mode_i ? miso : mosi;
	spi_clock_stop i_spi_clock_stop (.core_clk_i, .rst_i, .master_mode_i, .clock_stop_phase_sel_i,
		.tx_clock_polarity_i, .tx_sync_polarity_i, .rx_sync_polarity_i, .tx_clock_direction_i,
		.rx_clock_direction_i, .tx_sync_direction_i, .rx_sync_direction_i, .rate_gen_source_sel_i,
		.rate_gen_divider_i, .config_error_o, .ext_rate_clk_i, .tx_bit_clock_i(sck),
		.tx_bit_clock_o, .tx_bit_clock_oe_o, .tx_frame_sync_i(csn), .tx_frame_sync_o,
		.tx_frame_sync_oe_o, .rx_bit_clock_i(sck), .rx_frame_sync_i(csn), .serial_data_in_i,
		.serial_data_out_o, .serial_data_out_oe_o, .tx_data_i, .tx_valid_i, .tx_ready_o,
		.rx_data_o, .rx_valid_o, .rx_ready_i, .rx_overrun_o);
	spi_slave_model i_spi_slave_model (.sclk_i(tx_bit_clock_o), .cs_n_i(tx_frame_sync_o),
		.mosi_i(serial_data_out_o), .late_i(clock_stop_phase_sel_i[0]), .tx_byte_i(pbyte),
		.miso_o(miso), .rx_byte_o(prx));
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		ext_cnt <= ext_cnt + 2'h1;
		if (tx_ready_o === 1'b1) takes++;
		if (rx_valid_o === 1'b1 && rx_ready_i) rxq.push_back(rx_data_o);
	end
	// Lead-in low phase is overwritten by the interior ones
	always @(negedge core_clk_i) begin
		if (tx_bit_clock_o !== prev && prev) hlen = run;
		if (tx_bit_clock_o !== prev && !prev && !tx_frame_sync_o) llen = run;
		run = (tx_bit_clock_o !== prev) ? 1 : run + 1;
		prev = tx_bit_clock_o;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Bounded wait; a timeout shows up as a mismatch
	task automatic wait_for(ref logic s, input logic v);
		for (int n = 0; n < 3000 && s !== v; n++) @(posedge core_clk_i);
		chk({7'h0, s}, {7'h0, v});
	endtask
	task automatic mxfer(input logic [1:0] ph, input logic [7:0] dout, input logic [7:0] din);
		clock_stop_phase_sel_i <= ph;
		pbyte <= din;
		tx_data_i <= dout;
		tx_valid_i <= 1'b1;
		wait_for(tx_ready_o, 1'b1);
		tx_valid_i <= 1'b0;
		wait_for(tx_frame_sync_o, 1'b1);
		repeat (6) @(posedge core_clk_i);
		chk(prx, dout);
		chk(rxq.pop_front(), din);
	endtask
	task automatic sxfer(input logic [7:0] dout, input logic [7:0] din);
		logic [7:0] got;
		tx_data_i <= dout;
		tx_valid_i <= 1'b1;
		csn <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		tx_valid_i <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			mosi <= din[i];
			repeat (4) @(posedge core_clk_i);
			sck <= 1'b1;
			repeat (4) @(posedge core_clk_i);
			got[i] = serial_data_out_o;
			sck <= 1'b0;
		end
		repeat (4) @(posedge core_clk_i);
		csn <= 1'b1;
		mosi <= ~mosi;
		repeat (6) @(posedge core_clk_i);
		chk(got, dout);
		chk({7'h0, serial_data_out_oe_o}, 8'h00);
		chk(rxq.pop_front(), din);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Whole run needs about 2000 cycles; allow fifteen times that
	initial begin
		#300000;
		mismatches++;
		complete_run();
	end
	initial begin
		{rst_i, sck, csn, mosi, tx_valid_i, rx_ready_i, ext_cnt} = 8'b10100100;
		{master_mode_i, tx_clock_polarity_i, tx_sync_polarity_i, rx_sync_polarity_i} = 4'b1011;
		{tx_clock_direction_i, tx_sync_direction_i, rx_clock_direction_i, rx_sync_direction_i} = 4'hc;
		{rate_gen_source_sel_i, rate_gen_divider_i, tx_data_i, pbyte} = {1'b1, 8'h01, 16'h0};
		clock_stop_phase_sel_i = STOP_SAMPLE_FALL;
		repeat (12) @(posedge core_clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		chk({5'h0, config_error_o, tx_bit_clock_oe_o, tx_frame_sync_oe_o}, 8'h03);
		chk({7'h0, tx_frame_sync_o}, 8'h01);
		mxfer(STOP_SAMPLE_FALL, 8'hc9, 8'h36);
		mxfer(STOP_SAMPLE_RISE, 8'ha5, 8'h5a);
		$display("test master_modes done");
		for (int d = 0; d < 5; d++) begin
			rate_gen_divider_i <= d[7:0];
			mxfer(STOP_SAMPLE_FALL, 8'h81 + d[7:0], 8'h7e - d[7:0]);
			// A zero divider cannot make half-tick phases: one tick each
			chk(8'(hlen), 8'(d == 0 ? 1 : (d % 2 == 0 ? d / 2 + 1 : (d + 1) / 2)));
			chk(8'(llen), 8'(d == 0 ? 1 : (d % 2 == 0 ? d / 2 : (d + 1) / 2)));
			chk(8'(hlen + llen), 8'(d == 0 ? 2 : d + 1));
		end
		rate_gen_source_sel_i <= 1'b0;
		rate_gen_divider_i <= 8'h01;
		mxfer(STOP_SAMPLE_FALL, 8'h3c, 8'hc5);
		chk(8'(hlen + llen), 8'h08);
		rate_gen_source_sel_i <= 1'b1;
		$display("test divider done");
		rx_ready_i <= 1'b0;
		takes = 0;
		pbyte <= 8'h96;
		tx_valid_i <= 1'b1;
		repeat (1500) @(posedge core_clk_i);
		tx_valid_i <= 1'b0;
		chk(8'(takes), 8'h21);
		rx_ready_i <= 1'b1;
		repeat (80) @(posedge core_clk_i);
		chk(8'(rxq.size()), 8'h21);
		while (rxq.size() > 0) chk(rxq.pop_front(), 8'h96);
		$display("test fifo done");
		{master_mode_i, tx_clock_direction_i, tx_sync_direction_i} <= 3'b000;
		clock_stop_phase_sel_i <= STOP_SAMPLE_RISE;
		repeat (3) @(posedge core_clk_i);
		chk({5'h0, config_error_o, tx_bit_clock_oe_o, tx_frame_sync_oe_o}, 8'h00);
		sxfer(8'h6b, 8'hd4);
		rate_gen_divider_i <= 8'h02;
		repeat (3) @(posedge core_clk_i);
		chk({7'h0, config_error_o}, 8'h01);
		$display("test slave done");
		complete_run();
	end
endmodule
`default_nettype wire

// ### dv/spi_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
	// Link pins seen by the far-side slave
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	input wire logic late_i,
	// Byte to return and byte captured
	input wire logic [7:0] tx_byte_i,
	output logic miso_o,
	output logic [7:0] rx_byte_o
);
	logic [7:0] sh;
	initial begin
		miso_o = 1'b0;
		rx_byte_o = 8'h00;
		sh = 8'h00;
	end
	always @(negedge cs_n_i) begin
		sh = tx_byte_i;
		if (late_i) begin
			miso_o = sh[7];
			sh = sh << 1;
		end
	end
	// Deselected line flips so a stale bit never passes for data
	always @(posedge cs_n_i) miso_o = ~miso_o;
	always @(posedge sclk_i) begin
		if (!cs_n_i && late_i) begin
			rx_byte_o = {rx_byte_o[6:0], mosi_i};
		end else if (!cs_n_i) begin
			miso_o = sh[7];
			sh = sh << 1;
		end
	end
	always @(negedge sclk_i) begin
		if (!cs_n_i && !late_i) begin
			rx_byte_o = {rx_byte_o[6:0], mosi_i};
		end else if (!cs_n_i) begin
			miso_o = sh[7];
			sh = sh << 1;
		end
	end
endmodule
`default_nettype wire

// ### logic/spi_clock_stop.sv
// Contract
// - Generated bit clock period is (divider + 1) rate generator input periods; the code gives 2 for divider 0.
// - High phase is divider/2+1 periods when even, (divider+1)/2 when odd or zero; the code gives 1 for zero.
// - Low phase is divider/2 periods when even, (divider+1)/2 when odd or zero; the code gives 1 for zero.
// - Rate generator input is CPU clock when source select is 1, else external pin.
// - Slave mode needs source select 1 and divider 1.
// - Master with sync polarity 1 drives the frame sync inverted as active-low enable.
// - Slave inverts both active-low frame sync inputs into internal active-high frame.
// - Master: transmit clock and sync are outputs, receive clock and sync inputs.
// - Slave: all clock and frame sync directions are inputs.
// - Enable goes low before first rising clock edge; transfer starts on that edge.
// - Setting 10b samples on falling edge and launches on rising edge.
// - Setting 11b samples on rising edge and launches on falling edge.
// - Master waits one low phase (10b) or full period (11b) before first rise.
// - Master holds enable a full period (10b) or low phase (11b) after last fall.
// - Master in 10b releases data one low phase after the last falling edge.
// - Slave releases data output once enable deasserts after the last bit.
// - Slave presents first bit on enable low; master 11b one high phase after enable.
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Fill side
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	// Drain side
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_fifo
		$error("word_fifo: DEPTH must be a power of two of at least 2");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic rdy_q, rdy_d, ov_q, ov_d;
	logic [WIDTH-1:0] od_q, od_d;
	logic push, pop;
	always_comb begin
		push = in_valid_i && rdy_q;
		// The output word is a register of its own so the drain side sees flop outputs
		pop = (!ov_q || out_ready_i) && (cnt_q != '0);
		wr_d = push ? wr_q + 1'b1 : wr_q;
		rd_d = pop ? rd_q + 1'b1 : rd_q;
		cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		rdy_d = cnt_d < (AW + 1)'(DEPTH);
		ov_d = pop ? 1'b1 : (out_ready_i ? 1'b0 : ov_q);
		od_d = pop ? mem_q[rd_q] : od_q;
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			rdy_q <= 1'b1;
			ov_q <= 1'b0;
			od_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
			rdy_q <= rdy_d;
			ov_q <= ov_d;
			od_q <= od_d;
		end
	end
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				mem_q[i] <= '0;
			end else if (push && wr_q == AW'(i)) begin
				mem_q[i] <= in_data_i;
			end
		end
	end
	assign in_ready_o = rdy_q;
	assign out_valid_o = ov_q;
	assign out_data_o = od_q;
endmodule

module spi_clock_stop #(
	parameter int WORD_W = spi_clock_stop_pkg::WORD_W_DEF,
	parameter int DIV_W = spi_clock_stop_pkg::DIV_W_DEF,
	parameter int FIFO_DEPTH = spi_clock_stop_pkg::FIFO_DEPTH_DEF
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Mode and configuration
	input wire logic master_mode_i,
	input wire logic [1:0] clock_stop_phase_sel_i,
	input wire logic tx_clock_polarity_i,
	input wire logic tx_sync_polarity_i,
	input wire logic rx_sync_polarity_i,
	input wire logic tx_clock_direction_i,
	input wire logic rx_clock_direction_i,
	input wire logic tx_sync_direction_i,
	input wire logic rx_sync_direction_i,
	input wire logic rate_gen_source_sel_i,
	input wire logic [DIV_W-1:0] rate_gen_divider_i,
	output logic config_error_o,
	// External rate clock pin
	input wire logic ext_rate_clk_i,
	// Serial pins
	input wire logic tx_bit_clock_i,
	output logic tx_bit_clock_o,
	output logic tx_bit_clock_oe_o,
	input wire logic tx_frame_sync_i,
	output logic tx_frame_sync_o,
	output logic tx_frame_sync_oe_o,
	input wire logic rx_bit_clock_i,
	input wire logic rx_frame_sync_i,
	input wire logic serial_data_in_i,
	output logic serial_data_out_o,
	output logic serial_data_out_oe_o,
	// Transmit words
	input wire logic [WORD_W-1:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	// Receive words
	output logic [WORD_W-1:0] rx_data_o,
	output logic rx_valid_o,
	input wire logic rx_ready_i,
	output logic rx_overrun_o
);
	import spi_clock_stop_pkg::*;
	localparam int CW = $clog2(WORD_W + 1);
	if (WORD_W < 2 || DIV_W < 1 || DIV_W > 16) begin : g_bad_cfg
		$error("spi_clock_stop: WORD_W must be >= 2 and DIV_W in 1..16");
	end

	// Rate generator
	logic gen_q, gen_d, ext_prev_q, tick, ph_edge, rise_ev, fall_ev, odd_or_zero;
	logic [DIV_W:0] gcnt_q, gcnt_d, div_x, hi_len, lo_len, ph_len;
	always_comb begin
		div_x = {1'b0, rate_gen_divider_i};
		odd_or_zero = rate_gen_divider_i[0] || (rate_gen_divider_i == '0);
		hi_len = odd_or_zero ? (div_x + 1'b1) >> 1 : (div_x >> 1) + 1'b1;
		lo_len = odd_or_zero ? (div_x + 1'b1) >> 1 : div_x >> 1;
		ph_len = gen_q ? hi_len : lo_len;
		// A zero divider cannot make a half-period phase; it runs one input period each
		if (ph_len == '0) begin
			ph_len = (DIV_W + 1)'(1);
		end
		tick = rate_gen_source_sel_i ? 1'b1 : (ext_rate_clk_i && !ext_prev_q);
		ph_edge = tick && (gcnt_q >= ph_len - 1'b1);
		rise_ev = ph_edge && !gen_q;
		fall_ev = ph_edge && gen_q;
		gen_d = ph_edge ? !gen_q : gen_q;
		gcnt_d = !tick ? gcnt_q : (ph_edge ? '0 : gcnt_q + 1'b1);
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			gen_q <= 1'b0;
			gcnt_q <= '0;
			ext_prev_q <= 1'b0;
		end else begin
			gen_q <= gen_d;
			gcnt_q <= gcnt_d;
			ext_prev_q <= ext_rate_clk_i;
		end
	end

	// Slave pin history, used for edge detection
	logic sck_prev_q, rck_prev_q, fx_prev_q;
	logic fx_act, fr_act, sck_lvl, rck_lvl, fx_start, s_launch, s_sample, p11;
	always_comb begin
		fx_act = tx_frame_sync_i ^ tx_sync_polarity_i;
		fr_act = rx_frame_sync_i ^ rx_sync_polarity_i;
		sck_lvl = tx_bit_clock_i ^ tx_clock_polarity_i;
		rck_lvl = rx_bit_clock_i ^ tx_clock_polarity_i;
		fx_start = fx_act && !fx_prev_q;
		s_launch = p11 ? (sck_prev_q && !sck_lvl) : (!sck_prev_q && sck_lvl);
		s_sample = p11 ? (!rck_prev_q && rck_lvl) : (rck_prev_q && !rck_lvl);
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sck_prev_q <= 1'b0;
			rck_prev_q <= 1'b0;
			fx_prev_q <= 1'b0;
		end else begin
			sck_prev_q <= sck_lvl;
			rck_prev_q <= rck_lvl;
			fx_prev_q <= fx_act;
		end
	end

	// Transfer engine
	xfer_state_t st_q, st_d;
	logic [WORD_W-1:0] sh_q, sh_d, rxw_q, rxw_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic sclk_q, sclk_d, frame_q, frame_d, dout_q, dout_d, doe_q, doe_d;
	logic push_q, push_d, rdy_q, rdy_d, ovr_q, ovr_d, err_q, err_d;
	logic sclk_pin_q, fs_pin_q, clk_oe_q, fs_oe_q;
	logic stop_on, launch_ev, sample_ev, rx_in_ready, release_ev;
	always_comb begin
		stop_on = clock_stop_phase_sel_i[1];
		p11 = clock_stop_phase_sel_i == STOP_SAMPLE_RISE;
		launch_ev = p11 ? fall_ev : rise_ev;
		sample_ev = p11 ? rise_ev : fall_ev;
		release_ev = p11 ? rise_ev : fall_ev;
		st_d = st_q;
		sh_d = sh_q;
		rxw_d = rxw_q;
		cnt_d = cnt_q;
		sclk_d = sclk_q;
		frame_d = frame_q;
		dout_d = dout_q;
		doe_d = doe_q;
		push_d = 1'b0;
		rdy_d = 1'b0;
		ovr_d = 1'b0;
		if (!stop_on || !master_mode_i && st_q != ST_IDLE) begin
			st_d = ST_IDLE;
			sclk_d = 1'b0;
			frame_d = 1'b0;
			doe_d = 1'b0;
		end else if (master_mode_i) begin
			unique case (st_q)
				ST_IDLE: begin
					sclk_d = 1'b0;
					// Start only with room for the answer word, so the receive side never drops
					if (tx_valid_i && rx_in_ready && (p11 ? rise_ev : fall_ev)) begin
						frame_d = 1'b1;
						sh_d = tx_data_i;
						rdy_d = 1'b1;
						cnt_d = '0;
						st_d = ST_LEAD;
					end
				end
				ST_LEAD: begin
					if (launch_ev) begin
						dout_d = sh_q[WORD_W-1];
						doe_d = 1'b1;
						if (!p11) begin
							sclk_d = 1'b1;
							st_d = ST_SHIFT;
						end
					end else if (sample_ev) begin
						sclk_d = 1'b1;
						sh_d = {sh_q[WORD_W-2:0], serial_data_in_i};
						cnt_d = cnt_q + 1'b1;
						st_d = ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (rise_ev) begin
						sclk_d = 1'b1;
					end
					if (fall_ev) begin
						sclk_d = 1'b0;
					end
					if (sample_ev) begin
						sh_d = {sh_q[WORD_W-2:0], serial_data_in_i};
						cnt_d = cnt_q + 1'b1;
						if (!p11 && cnt_q == CW'(WORD_W - 1)) begin
							st_d = ST_TAIL;
						end
					end
					if (launch_ev) begin
						if (p11 && cnt_q == CW'(WORD_W)) begin
							doe_d = 1'b0;
							st_d = ST_TAIL;
						end else begin
							dout_d = sh_q[WORD_W-1];
						end
					end
				end
				ST_TAIL: begin
					if (!p11 && rise_ev) begin
						doe_d = 1'b0;
					end
					if (release_ev) begin
						frame_d = 1'b0;
						doe_d = 1'b0;
						push_d = 1'b1;
						rxw_d = sh_q;
						st_d = ST_IDLE;
					end
				end
			endcase
		end else if (fx_start) begin
			sh_d = tx_valid_i ? tx_data_i : '0;
			rdy_d = tx_valid_i;
			dout_d = tx_valid_i && tx_data_i[WORD_W-1];
			doe_d = 1'b1;
			cnt_d = '0;
			frame_d = 1'b1;
		end else if (frame_q) begin
			if (!fx_act) begin
				doe_d = 1'b0;
				frame_d = 1'b0;
			end else begin
				if (s_sample && fr_act) begin
					sh_d = {sh_q[WORD_W-2:0], serial_data_in_i};
					cnt_d = cnt_q + 1'b1;
					if (cnt_q == CW'(WORD_W - 1)) begin
						cnt_d = '0;
						rxw_d = sh_d;
						push_d = rx_in_ready;
						ovr_d = !rx_in_ready;
					end
				end
				if (s_launch) begin
					dout_d = sh_q[WORD_W-1];
				end
			end
		end
		err_d = master_mode_i
			? !(tx_clock_direction_i && tx_sync_direction_i
				&& !rx_clock_direction_i && !rx_sync_direction_i
				&& tx_sync_polarity_i && rx_sync_polarity_i)
			: (tx_clock_direction_i || rx_clock_direction_i
				|| tx_sync_direction_i || rx_sync_direction_i
				|| !rate_gen_source_sel_i
				|| rate_gen_divider_i != DIV_W'(SLAVE_DIVIDER));
	end
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= ST_IDLE;
			sh_q <= '0;
			rxw_q <= '0;
			cnt_q <= '0;
			sclk_q <= 1'b0;
			frame_q <= 1'b0;
			dout_q <= 1'b0;
			doe_q <= 1'b0;
			push_q <= 1'b0;
			rdy_q <= 1'b0;
			ovr_q <= 1'b0;
			err_q <= 1'b0;
			sclk_pin_q <= RST_BIT_CLOCK_PIN;
			fs_pin_q <= RST_FRAME_PIN;
			clk_oe_q <= 1'b0;
			fs_oe_q <= 1'b0;
		end else begin
			st_q <= st_d;
			sh_q <= sh_d;
			rxw_q <= rxw_d;
			cnt_q <= cnt_d;
			sclk_q <= sclk_d;
			frame_q <= frame_d;
			dout_q <= dout_d;
			doe_q <= doe_d;
			push_q <= push_d;
			rdy_q <= rdy_d;
			ovr_q <= ovr_d;
			err_q <= err_d;
			sclk_pin_q <= sclk_d ^ tx_clock_polarity_i;
			fs_pin_q <= frame_d ^ tx_sync_polarity_i;
			clk_oe_q <= tx_clock_direction_i;
			fs_oe_q <= tx_sync_direction_i;
		end
	end

	word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk_i(core_clk_i),
		.rst_i(rst_i),
		.in_valid_i(push_q),
		.in_data_i(rxw_q),
		.in_ready_o(rx_in_ready),
		.out_valid_o(rx_valid_o),
		.out_data_o(rx_data_o),
		.out_ready_i(rx_ready_i)
	);

	assign config_error_o = err_q;
	assign tx_bit_clock_o = sclk_pin_q;
	assign tx_bit_clock_oe_o = clk_oe_q;
	assign tx_frame_sync_o = fs_pin_q;
	assign tx_frame_sync_oe_o = fs_oe_q;
	assign serial_data_out_o = dout_q;
	assign serial_data_out_oe_o = doe_q;
	assign tx_ready_o = rdy_q;
	assign rx_overrun_o = ovr_q;
endmodule
`default_nettype wire

// ### logic/spi_clock_stop_pkg.sv
`default_nettype none
package spi_clock_stop_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int WORD_W_DEF = 8;
	localparam int DIV_W_DEF = 8;
	localparam int FIFO_DEPTH_DEF = 32;
	// Clock-stop settings; the upper bit switches clock-stop operation on
	localparam logic [1:0] STOP_SAMPLE_FALL = 2'h2;
	localparam logic [1:0] STOP_SAMPLE_RISE = 2'h3;
	localparam logic [7:0] SLAVE_DIVIDER = 8'h01;
	// Reset levels of the pins: bit clock low, slave enable deasserted high
	localparam logic RST_BIT_CLOCK_PIN = 1'b0;
	localparam logic RST_FRAME_PIN = 1'b1;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_LEAD = 2'h1,
		ST_SHIFT = 2'h3,
		ST_TAIL = 2'h2
	} xfer_state_t;
endpackage
`default_nettype wire
